// File: hw/pfm_pad_mux.sv
// pad configuration and function multiplexer top
// pad data synchronised here by two register stages
// Operation
// - wakeup pads except the two that never wake from standby take wakeup unit settings
// - other pads return to reset settings
// - test output pad: input, no pull, standby
// - field 00/01/1x picks slot 0/1/2
// - peripheral input usable only with input enable; wake and irq paths ignore it
// - pad input fans to all listed peripherals
// - source select picks peripheral input pad
// - reset configuration holds during and after reset
// - nmi overrides alternate function field
// - test port pins reset to test functions
// - test output resets slot 2, medium drive
// - test output enable resets to one
// - gpio select enables test output buffer
// - two pads never wake from standby
// - wakeup pins also raise external irq
`timescale 1ns/10ps
module pfm_pad_mux #(
    parameter int NP = pfm_pkg::NUM_PINS,
    parameter int NS = pfm_pkg::NUM_SRC_SEL
) (
    // clock and reset
    input  wire logic                           clk_i,
    input  wire logic                           rst_n_i,
    // config access
    input  wire logic                           cfg_wr_i,
    input  wire logic [pfm_pkg::PIN_W-1:0]      cfg_idx_i,
    input  wire logic [pfm_pkg::CFG_W-1:0]      cfg_wdata_i,
    output logic      [pfm_pkg::CFG_W-1:0]      cfg_rdata_o,
    input  wire logic                           src_wr_i,
    input  wire logic [2:0]                     src_idx_i,
    input  wire logic [pfm_pkg::PIN_W-1:0]      src_wdata_i,
    // power mode and wakeup unit
    input  wire logic                           stby_i,
    input  wire logic                           stby_exit_i,
    input  wire logic [NP-1:0]                  wk_ibe_i,
    input  wire logic [NP-1:0]                  wk_pull_i,
    input  wire logic [NP-1:0]                  nmi_sel_i,
    input  wire logic                           nmi_out_i,
    // peripheral side
    input  wire logic [NP*3-1:0]                slot_out_i,
    input  wire logic [NP*3-1:0]                slot_oe_i,
    output logic      [NP-1:0]                  periph_in_o,
    output logic      [NS-1:0]                  sel_in_o,
    output logic      [NP-1:0]                  wake_o,
    output logic      [NP-1:0]                  external_irq_input_o,
    // pads
    input  wire logic [NP-1:0]                  pad_in_i,
    output logic      [NP-1:0]                  pad_out_o,
    output logic      [NP-1:0]                  pad_oe_o,
    output logic      [NP-1:0]                  pad_ie_o,
    output logic      [NP-1:0]                  pad_pull_o,
    output logic      [NP-1:0]                  pad_pup_o,
    output logic      [NP-1:0]                  pad_drv_o
);
    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [NP-1:0][pfm_pkg::CFG_W-1:0] cfg;
        logic [NS-1:0][pfm_pkg::PIN_W-1:0] src;
        logic [NP-1:0]                     in_s1;
        logic [NP-1:0]                     in_s2;
        logic [pfm_pkg::CFG_W-1:0]         rdata;
        logic [NP-1:0]                     pin;
        logic [NS-1:0]                     sel;
        logic [NP-1:0]                     wake;
        logic [NP-1:0]                     irq;
        logic [NP-1:0]                     out;
        logic [NP-1:0]                     oe;
        logic [NP-1:0]                     ie;
        logic [NP-1:0]                     pull;
        logic [NP-1:0]                     pup;
        logic [NP-1:0]                     drv;
    } pfm_state_type;
    pfm_state_type state_reg, state_next;

    logic [NP-1:0] c_out;
    logic [NP-1:0] c_oe;
    logic [NP-1:0] c_ie;
    logic [NP-1:0] c_pull;
    logic [NP-1:0] c_pup;
    logic [NP-1:0] c_drv;

    // ****************************************
    // reset image and wakeup masks
    // ****************************************
    function automatic logic [pfm_pkg::CFG_W-1:0] rst_cfg(input int p);
        if (p == pfm_pkg::PIN_TDI)      rst_cfg = pfm_pkg::CFG_RST_TDI;
        else if (p == pfm_pkg::PIN_TDO) rst_cfg = pfm_pkg::CFG_RST_TDO;
        else if (p == pfm_pkg::PIN_TCK) rst_cfg = pfm_pkg::CFG_RST_TCK;
        else if (p == pfm_pkg::PIN_TMS) rst_cfg = pfm_pkg::CFG_RST_TMS;
        else                            rst_cfg = pfm_pkg::CFG_RST_DEFAULT;
    endfunction

    // whole reset image, so the reset branch loads constants only
    function automatic logic [NP-1:0][pfm_pkg::CFG_W-1:0] rst_image();
        for (int p = 0; p < NP; p++) begin
            rst_image[p] = rst_cfg(p);
        end
    endfunction

    localparam logic [NP-1:0][pfm_pkg::CFG_W-1:0] RST_IMAGE = rst_image();
    // every pad served by the wakeup unit, standby wake or not
    localparam logic [NP-1:0] WK_UNIT_MASK = NP'(pfm_pkg::WKUP_STBY_MASK | pfm_pkg::WKUP_NO_STBY_MASK);
    localparam logic [NP-1:0] WK_NO_STBY   = NP'(pfm_pkg::WKUP_NO_STBY_MASK);

    // ****************************************
    // pad slices
    // ****************************************
    for (genvar g = 0; g < NP; g++) begin : g_pad
        pfm_pad_slice #(.CW(pfm_pkg::CFG_W)) u_slice (
            .cfg_i      (state_reg.cfg[g]),
            .wk_cfg_i   ({wk_pull_i[g], wk_ibe_i[g]}),
            .stby_i     (stby_i),
            .wk_owned_i (pfm_pkg::WKUP_STBY_MASK[g]),
            .nmi_sel_i  (nmi_sel_i[g]),
            .nmi_out_i  (nmi_out_i),
            .slot_out_i (slot_out_i[g*3 +: 3]),
            .slot_oe_i  (slot_oe_i[g*3 +: 3]),
            .pad_out_o  (c_out[g]),
            .pad_oe_o   (c_oe[g]),
            .pad_ie_o   (c_ie[g]),
            .pad_pull_o (c_pull[g]),
            .pad_pup_o  (c_pup[g]),
            .pad_drv_o  (c_drv[g])
        );
    end

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        state_next       = state_reg;
        state_next.in_s1 = pad_in_i;
        state_next.in_s2 = state_reg.in_s1;
        if (cfg_wr_i) begin
            state_next.cfg[cfg_idx_i] = cfg_wdata_i;
        end
        if (src_wr_i) begin
            state_next.src[src_idx_i] = src_wdata_i;
        end
        // standby exit beats a config write in the same cycle
        if (stby_exit_i) begin
            state_next.cfg = RST_IMAGE;
            for (int p = 0; p < NP; p++) begin
                if (pfm_pkg::WKUP_STBY_MASK[p]) begin
                    state_next.cfg[p][pfm_pkg::CFG_IBE_BIT]  = wk_ibe_i[p];
                    state_next.cfg[p][pfm_pkg::CFG_PULL_BIT] = wk_pull_i[p];
                end
            end
        end
        // ****************************************
        // readback and input paths
        // ****************************************
        state_next.rdata = state_reg.cfg[cfg_idx_i];
        for (int p = 0; p < NP; p++) begin
            state_next.pin[p]  = state_reg.in_s2[p] & state_reg.cfg[p][pfm_pkg::CFG_IBE_BIT];
            state_next.wake[p] = state_reg.in_s2[p] & WK_UNIT_MASK[p]
                                 & ~(stby_i & WK_NO_STBY[p]);
            state_next.irq[p]  = state_reg.in_s2[p] & WK_UNIT_MASK[p];
        end
        for (int s = 0; s < NS; s++) begin
            state_next.sel[s] = state_reg.pin[state_reg.src[s]];
        end
        // pad controls from the slices
        state_next.out  = c_out;
        state_next.oe   = c_oe;
        state_next.ie   = c_ie;
        state_next.pull = c_pull;
        state_next.pup  = c_pup;
        state_next.drv  = c_drv;
        // test output pad sits in the standby domain as a plain input
        if (stby_i) begin
            state_next.ie[pfm_pkg::PIN_TDO]   = 1'b1;
            state_next.oe[pfm_pkg::PIN_TDO]   = 1'b0;
            state_next.pull[pfm_pkg::PIN_TDO] = 1'b0;
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg     <= '0;
            state_reg.cfg <= RST_IMAGE;
            for (int p = 0; p < NP; p++) begin
                state_reg.ie[p]   <= RST_IMAGE[p][pfm_pkg::CFG_IBE_BIT];
                state_reg.pull[p] <= RST_IMAGE[p][pfm_pkg::CFG_PULL_BIT];
                state_reg.pup[p]  <= RST_IMAGE[p][pfm_pkg::CFG_PUP_BIT];
            end
        end else begin
            state_reg <= state_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign cfg_rdata_o          = state_reg.rdata;
    assign periph_in_o          = state_reg.pin;
    assign sel_in_o             = state_reg.sel;
    assign wake_o               = state_reg.wake;
    assign external_irq_input_o = state_reg.irq;
    assign pad_out_o            = state_reg.out;
    assign pad_oe_o             = state_reg.oe;
    assign pad_ie_o             = state_reg.ie;
    assign pad_pull_o           = state_reg.pull;
    assign pad_pup_o            = state_reg.pup;
    assign pad_drv_o            = state_reg.drv;
endmodule // pfm_pad_mux

// File: hw/pfm_pad_slice.sv
// one pad: output slot select, buffer gating and standby handling
// assumes registered config from the top module
`timescale 1ns/10ps
module pfm_pad_slice #(
    parameter int CW = 7
) (
    // config
    input  wire logic [CW-1:0] cfg_i,
    input  wire logic [1:0]    wk_cfg_i,
    input  wire logic          stby_i,
    input  wire logic          wk_owned_i,
    input  wire logic          nmi_sel_i,
    input  wire logic          nmi_out_i,
    // function slots
    input  wire logic [2:0]    slot_out_i,
    input  wire logic [2:0]    slot_oe_i,
    // pad side
    output logic               pad_out_o,
    output logic               pad_oe_o,
    output logic               pad_ie_o,
    output logic               pad_pull_o,
    output logic               pad_pup_o,
    output logic               pad_drv_o
);
    logic [1:0] afs;
    logic       slot_oe;
    logic       slot_o;
    always_comb begin
        afs = cfg_i[pfm_pkg::CFG_AFS_LSB +: 2];
        // slots 2 and 3 of the field both pick slot 2
        unique case (afs)
            pfm_pkg::AFS_SLOT0: begin
                slot_o  = slot_out_i[0];
                slot_oe = cfg_i[pfm_pkg::CFG_OBE_BIT];
            end
            pfm_pkg::AFS_SLOT1: begin
                slot_o  = slot_out_i[1];
                slot_oe = slot_oe_i[1];
            end
            default: begin
                slot_o  = slot_out_i[2];
                slot_oe = slot_oe_i[2];
            end
        endcase
        if (nmi_sel_i) begin
            slot_o  = nmi_out_i;
            slot_oe = 1'b0;
        end
        pad_out_o  = slot_o;
        pad_oe_o   = slot_oe & ~stby_i;
        pad_ie_o   = cfg_i[pfm_pkg::CFG_IBE_BIT];
        pad_pull_o = cfg_i[pfm_pkg::CFG_PULL_BIT];
        pad_pup_o  = cfg_i[pfm_pkg::CFG_PUP_BIT];
        pad_drv_o  = cfg_i[pfm_pkg::CFG_DRV_BIT];
        if (stby_i && wk_owned_i) begin
            pad_ie_o   = wk_cfg_i[0];
            pad_pull_o = wk_cfg_i[1];
        end
    end
endmodule // pfm_pad_slice

// File: pkg/pfm_pkg.sv
// package of constants for the pad function multiplexer
// assumes a generic pad ring with per-pin config registers
package pfm_pkg;
    localparam int NUM_PINS      = 128;
    localparam int PIN_W         = 7;
    localparam int NUM_SRC_SEL   = 8;
    localparam int SRC_SEL_W     = 2;
    // config register field positions
    localparam int CFG_W         = 7;
    localparam int CFG_AFS_LSB   = 0;
    localparam int CFG_IBE_BIT   = 2;
    localparam int CFG_OBE_BIT   = 3;
    localparam int CFG_PULL_BIT  = 4;
    localparam int CFG_PUP_BIT   = 5;
    localparam int CFG_DRV_BIT   = 6;
    // reset values
    localparam logic [6:0] CFG_RST_DEFAULT   = 7'h00;
    localparam logic [6:0] CFG_RST_TDI       = 7'h36;
    localparam logic [6:0] CFG_RST_TDO       = 7'h0a;
    localparam logic [6:0] CFG_RST_TCK       = 7'h36;
    localparam logic [6:0] CFG_RST_TMS       = 7'h36;
    // test-port pin indices
    localparam int PIN_TDI       = 32;
    localparam int PIN_TDO       = 33;
    localparam int PIN_TCK       = 121;
    localparam int PIN_TMS       = 122;
    // wakeup-capable pads kept by the wakeup unit in standby
    localparam logic [127:0] WKUP_STBY_MASK = 128'h0000_0000_0000_0000_0000_0000_0000_8017;
    // wakeup pads which cannot leave standby
    localparam logic [127:0] WKUP_NO_STBY_MASK = 128'h0000_0000_0000_0000_0000_0000_0300_0000;
    localparam logic [1:0] AFS_SLOT0 = 2'h0;
    localparam logic [1:0] AFS_SLOT1 = 2'h1;
endpackage

// File: verification/pfm_pad_mux_properties.sv
// checker on the pad multiplexer top ports
// assumes a bind from the bench top file
`timescale 1ns/10ps
module pfm_pad_mux_properties #(
    parameter int NP = 128
) (
    input wire logic          clk_i, rst_n_i, cfg_wr_i, stby_i, stby_exit_i, nmi_out_i,
    input wire logic [6:0]    cfg_idx_i, cfg_wdata_i, cfg_rdata_o,
    input wire logic [NP-1:0] wk_ibe_i, wk_pull_i, nmi_sel_i, pad_in_i, periph_in_o, wake_o,
    input wire logic [NP-1:0] external_irq_input_o, pad_out_o, pad_oe_o, pad_ie_o,
    input wire logic [NP-1:0] pad_pull_o, pad_pup_o, pad_drv_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    AST_RST_TDO: assert property ($rose(rst_n_i) |-> !pad_oe_o[33] && !pad_ie_o[33] && !pad_drv_o[33])
        else $error("test output pad not tristate at reset");
    AST_RST_TST: assert property ($rose(rst_n_i) |-> pad_ie_o[32] && pad_pup_o[32] && pad_pup_o[122])
        else $error("test input pads lack pull-up at reset");
    AST_STBY_OFF: assert property (stby_i [*2] |-> pad_oe_o == '0)
        else $error("output driven in standby");
    AST_STBY_TDO: assert property (stby_i [*2] |-> pad_ie_o[33] && !pad_pull_o[33])
        else $error("test output pad wrong in standby");
    AST_WK_CFG: assert property (stby_i [*2] |-> pad_ie_o[0] == $past(wk_ibe_i[0]) && pad_pull_o[0] == $past(wk_pull_i[0]))
        else $error("wakeup pad ignores wakeup settings");
    AST_NO_WAKE: assert property (stby_i [*3] |-> !wake_o[24] && !wake_o[25])
        else $error("standby wake from excluded pad");
    AST_WAKE_RUN: assert property (!stby_i && $past(pad_in_i[24], 2) |=> wake_o[24])
        else $error("excluded pad does not wake outside standby");
    AST_IRQ: assert property (wake_o[0] |-> external_irq_input_o[0])
        else $error("wakeup pad without irq");
    AST_NMI: assert property (nmi_sel_i[6] && !stby_i |=> pad_out_o[6] == $past(nmi_out_i) && !pad_oe_o[6])
        else $error("nmi not taking the pad");
    AST_IN: assert property (periph_in_o[5] |-> $past(pad_in_i[5], 3))
        else $error("peripheral input without pad level");
    AST_RD: assert property (cfg_wr_i && !stby_exit_i ##1 $stable(cfg_idx_i) |=> cfg_rdata_o == $past(cfg_wdata_i, 2))
        else $error("config readback differs from write");
endmodule // pfm_pad_mux_properties

// File: verification/pfm_pad_mux_test.sv
// self-checking bench for the pad multiplexer
// assumes the peripheral model and the bound checker
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
    $display("BAD %s exp %0h got %0h", nm, e, g); end end
module pfm_pad_mux_test;
    localparam int NP = 128;
    logic                          clk_i, rst_n_i, cfg_wr_i, src_wr_i, stby_i, stby_exit_i, nmi_out_i;
    logic [6:0]                    cfg_idx_i, cfg_wdata_i, src_wdata_i, cfg_rdata_o;
    logic [2:0]                    src_idx_i, slot_val;
    logic [7:0]                    sel_in_o;
    logic [NP-1:0]                 wk_ibe_i, wk_pull_i, nmi_sel_i, ext, pad_in_i, periph_in_o, wake_o;
    logic [NP-1:0]                 external_irq_input_o, pad_out_o, pad_oe_o, pad_ie_o, pad_pull_o, pad_pup_o, pad_drv_o;
    logic [NP*3-1:0]               slot_out_i, slot_oe_i;
    int                            bad_count, n_compared;
    pfm_pad_mux #(.NP(NP)) dut (
        .clk_i                (clk_i),
        .rst_n_i              (rst_n_i),
        .cfg_wr_i             (cfg_wr_i),
        .cfg_idx_i            (cfg_idx_i),
        .cfg_wdata_i          (cfg_wdata_i),
        .cfg_rdata_o          (cfg_rdata_o),
        .src_wr_i             (src_wr_i),
        .src_idx_i            (src_idx_i),
        .src_wdata_i          (src_wdata_i),
        .stby_i               (stby_i),
        .stby_exit_i          (stby_exit_i),
        .wk_ibe_i             (wk_ibe_i),
        .wk_pull_i            (wk_pull_i),
        .nmi_sel_i            (nmi_sel_i),
        .nmi_out_i            (nmi_out_i),
        .slot_out_i           (slot_out_i),
        .slot_oe_i            (slot_oe_i),
        .periph_in_o          (periph_in_o),
        .sel_in_o             (sel_in_o),
        .wake_o               (wake_o),
        .external_irq_input_o (external_irq_input_o),
        .pad_in_i             (pad_in_i),
        .pad_out_o            (pad_out_o),
        .pad_oe_o             (pad_oe_o),
        .pad_ie_o             (pad_ie_o),
        .pad_pull_o           (pad_pull_o),
        .pad_pup_o            (pad_pup_o),
        .pad_drv_o            (pad_drv_o)
    );
    pfm_periph_model #(.NP(NP)) peer (.slot_val_i(slot_val), .ext_i(ext), .pad_out_i(pad_out_o),
        .pad_oe_i(pad_oe_o), .slot_out_o(slot_out_i), .slot_oe_o(slot_oe_i), .pad_in_o(pad_in_i));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [6:0] idx, input logic [6:0] d);
        @(posedge clk_i);
        cfg_wr_i <= 1'b1;
        cfg_idx_i <= idx;
        cfg_wdata_i <= d;
        @(posedge clk_i);
        cfg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] idx, input logic [6:0] e, input string nm);
        @(posedge clk_i);
        cfg_idx_i <= idx;
        tick(2);
        `CHK(nm, e, cfg_rdata_o)
    endtask
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        {cfg_wr_i, src_wr_i, stby_i, stby_exit_i, nmi_out_i, rst_n_i} = '0;
        {cfg_idx_i, cfg_wdata_i, src_wdata_i, src_idx_i, slot_val} = '0;
        {wk_ibe_i, wk_pull_i, nmi_sel_i, ext} = '0;
        bad_count = 0;
        n_compared = 0;
        repeat (4) @(posedge clk_i);
        rst_n_i <= 1'b1;
        tick(1);
        `CHK("tdo drv", 1'b0, pad_drv_o[33])
        rd(7'd33, 7'h0a, "cfg tdo");
        rd(7'd32, pfm_pkg::CFG_RST_TDI, "cfg tdi");
        rd(7'd121, pfm_pkg::CFG_RST_TCK, "cfg tck");
        rd(7'd40, 7'h00, "cfg gpio");
        $display("test reset done");
        for (int a = 0; a < 4; a++) begin
            wr(7'd40, 7'h08 | 7'(a));
            for (int p = 0; p < 3; p++) begin
                @(posedge clk_i);
                slot_val <= 3'(1 << p);
                tick(2);
                `CHK("slot out", 1'((a > 2 ? 2 : a) == p), pad_out_o[40])
            end
        end
        wr(7'd33, 7'h08);
        tick(2);
        `CHK("tdo gpio oe", 1'b1, pad_oe_o[33])
        $display("test slots done");
        @(posedge clk_i);
        ext[5] <= 1'b1;
        tick(5);
        `CHK("in gated", 1'b0, periph_in_o[5])
        wr(7'd5, 7'h04);
        tick(5);
        `CHK("in open", 1'b1, periph_in_o[5])
        @(posedge clk_i);
        src_wr_i <= 1'b1;
        src_idx_i <= 3'd2;
        src_wdata_i <= 7'd5;
        @(posedge clk_i);
        src_wr_i <= 1'b0;
        nmi_sel_i[6] <= 1'b1;
        nmi_out_i <= 1'b1;
        tick(5);
        `CHK("src sel", 1'b1, sel_in_o[2])
        `CHK("nmi out", 1'b1, pad_out_o[6])
        $display("test inputs done");
        @(posedge clk_i);
        wk_ibe_i[0] <= 1'b1;
        wk_pull_i[0] <= 1'b1;
        ext[0] <= 1'b1;
        ext[24] <= 1'b1;
        stby_i <= 1'b1;
        tick(5);
        `CHK("wk cfg", 2'b11, {pad_ie_o[0], pad_pull_o[0]})
        `CHK("tdo stby", 2'b10, {pad_ie_o[33], pad_pull_o[33]})
        `CHK("no wake", 1'b0, wake_o[24])
        `CHK("irq", 1'b1, external_irq_input_o[0])
        `CHK("irq no stby pad", 1'b1, external_irq_input_o[24])
        @(posedge clk_i);
        stby_exit_i <= 1'b1;
        stby_i <= 1'b0;
        @(posedge clk_i);
        stby_exit_i <= 1'b0;
        rd(7'd40, 7'h00, "exit gpio");
        rd(7'd33, 7'h0a, "exit tdo");
        rd(7'd0, 7'h14, "exit wkup");
        `CHK("wake run", 1'b1, wake_o[24])
        $display("test standby done");
        results();
    end
endmodule // pfm_pad_mux_test
bind pfm_pad_mux pfm_pad_mux_properties #(.NP(NP)) u_props (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i), .stby_i(stby_i), .stby_exit_i(stby_exit_i),
    .nmi_out_i(nmi_out_i), .cfg_idx_i(cfg_idx_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .wk_ibe_i(wk_ibe_i), .wk_pull_i(wk_pull_i), .nmi_sel_i(nmi_sel_i), .pad_in_i(pad_in_i),
    .periph_in_o(periph_in_o), .wake_o(wake_o), .external_irq_input_o(external_irq_input_o),
    .pad_out_o(pad_out_o), .pad_oe_o(pad_oe_o), .pad_ie_o(pad_ie_o), .pad_pull_o(pad_pull_o),
    .pad_pup_o(pad_pup_o), .pad_drv_o(pad_drv_o)
);

// File: verification/pfm_periph_model.sv
// peripheral and board side of the pad multiplexer
// assumes pin g slot k at bit g*3+k
`timescale 1ns/10ps
module pfm_periph_model #(
    parameter int NP = 128
) (
    input  wire logic [2:0]      slot_val_i,
    input  wire logic [NP-1:0]   ext_i,
    input  wire logic [NP-1:0]   pad_out_i,
    input  wire logic [NP-1:0]   pad_oe_i,
    output logic      [NP*3-1:0] slot_out_o,
    output logic      [NP*3-1:0] slot_oe_o,
    output logic      [NP-1:0]   pad_in_o
);
    assign slot_out_o = {NP{slot_val_i}};
    assign slot_oe_o  = '1;
    // pad wins while it drives, else the board level
    assign pad_in_o   = (pad_oe_i & pad_out_i) | (~pad_oe_i & ext_i);
endmodule // pfm_periph_model
